// file: rtl/power_mode_defs.vh
// offsets, fields, reset values and counts of the power mode clock block
`ifndef POWER_MODE_DEFS_VH
`define POWER_MODE_DEFS_VH

// register byte addresses
`define ADDR_CFG 12'h000
`define ADDR_INTCTL 12'h004
`define ADDR_OSCCTL 12'h008
`define ADDR_TUNE 12'h00c
`define ADDR_IRQEN 12'h010
`define ADDR_IRQFLAG 12'h014
`define ADDR_STATUS 12'h018

// oscillator_control fields
`define OSC_IDLE_BIT 7
`define OSC_FREQ_MSB 6
`define OSC_FREQ_LSB 4
`define OSC_PRIRDY_BIT 3
`define OSC_INTSTB_BIT 2
`define OSC_SCS1_BIT 1
`define OSC_SCS0_BIT 0

// oscillator_config_high fields
`define CFG_DUAL_BIT 7
`define CFG_FMON_BIT 6
`define CFG_MODE_MSB 3
`define MODE_INT_BIT 3

// peripheral_irq_flag_2 / enable_2 field
`define FAIL_BIT 7

// reset values
`define OSCCTL_RST 8'h30
`define INTCTL_RST 8'h00
`define TUNE_RST 8'h00
`define IRQEN_RST 8'h00
`define IRQFLAG_RST 8'h00
`define CFG_RST 8'h00

// clock sources as selected and as active
`define SRC_PRI 2'b00
`define SRC_SEC 2'b01
`define SRC_INT 2'b10
`define SRC_NONE 2'b11

// primary oscillator modes: crystal modes are at or below this code
`define MODE_CRYSTAL_MAX 4'h2
`define FREQ_SLOW 3'h0

// counts
`define STARTUP_OSCILLATIONS 1024
`define SWITCH_OLD_EDGES 3
`define SWITCH_NEW_EDGES 3

`endif

// file: rtl/power_mode_clock_select.v
// power-managed mode and system clock source selection with APB registers
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_defs.vh"

module power_mode_clock_select #(
    parameter STARTUP_COUNT = `STARTUP_OSCILLATIONS,
    parameter OLD_EDGES = `SWITCH_OLD_EDGES,
    parameter NEW_EDGES = `SWITCH_NEW_EDGES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3:0] osc_mode_strap,
    input wire fail_monitor_enable,
    input wire dual_speed_start_enable,
    input wire primary_osc_in,
    input wire secondary_osc_in,
    input wire internal_osc_in,
    input wire secondary_osc_ready,
    input wire fast_internal_osc_stable,
    input wire primary_fail_detect,
    input wire sleep_request,
    input wire wake_event,
    output reg cpu_clk_enable,
    output reg periph_clk_enable,
    output reg [1:0] system_clk_source,
    output reg secondary_running_flag,
    output reg irq
);

    localparam [5:0] ST_RUN = 6'b000001;
    localparam [5:0] ST_WAIT = 6'b000010;
    localparam [5:0] ST_OLD = 6'b000100;
    localparam [5:0] ST_NEW = 6'b001000;
    localparam [5:0] ST_SLEEP = 6'b010000;
    localparam [5:0] ST_IDLE = 6'b100000;
    localparam integer START_LAST_I = STARTUP_COUNT - 1;
    localparam integer OLD_LAST_I = OLD_EDGES - 1;
    localparam integer NEW_LAST_I = NEW_EDGES - 1;
    localparam [10:0] START_LAST = START_LAST_I[10:0];
    localparam [3:0] OLD_LAST = OLD_LAST_I[3:0];
    localparam [3:0] NEW_LAST = NEW_LAST_I[3:0];

    // pin synchronisers: 0 pri osc, 1 sec osc, 2 int osc,
    // 3 sec ready, 4 int stable, 5 fail detect
    reg [5:0] s1_q;
    reg [5:0] s2_q;
    reg [5:0] s3_q;
    reg [5:0] filt_q;
    wire [5:0] pins;
    wire [5:0] agree;
    wire [5:0] filt_d;
    wire [5:0] rise;

    reg [7:0] cfg_q;
    reg [7:0] intctl_q;
    reg [7:0] oscctl_q;
    reg [7:0] tune_q;
    reg [7:0] irqen_q;
    reg [7:0] irqflag_q;
    reg primary_ready_flag_q;
    reg internal_stable_flag_q;
    reg secondary_flag_q;

    reg [5:0] state_q;
    reg [1:0] cur_q;
    reg [1:0] tgt_q;
    reg [3:0] edge_cnt_q;
    reg [10:0] start_cnt_q;
    reg start_run_q;
    reg start_done_q;
    reg fail_q;

    wire access;
    wire wr;
    wire rd;
    wire setup;
    wire crystal;
    wire int_primary;
    wire two_speed;
    wire start_ok;
    wire start_fin;
    wire [1:0] sel_src;
    wire [1:0] want;
    wire pri_ready;
    wire armed;
    wire fail_evt;
    wire scs1_tog;
    wire wake_restart;
    wire sleep_enter;
    wire fail_clear;
    wire [2:0] osc_rise;
    wire [2:0] src_ready;

    assign pins = {primary_fail_detect, fast_internal_osc_stable,
                   secondary_osc_ready, internal_osc_in,
                   secondary_osc_in, primary_osc_in};
    // a change counts once the second and third stages agree
    assign agree = ~(s2_q ^ s3_q);
    assign filt_d = (agree & s3_q) | (~agree & filt_q);
    assign rise = agree & s3_q & ~filt_q;
    assign osc_rise = rise[2:0];

    function pick;
        input [1:0] src;
        input [2:0] bits;
        begin
            case (src)
                `SRC_PRI: pick = bits[0];
                `SRC_SEC: pick = bits[1];
                `SRC_INT: pick = bits[2];
                default: pick = 1'b0;
            endcase
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            case (a)
                `ADDR_CFG, `ADDR_INTCTL, `ADDR_OSCCTL, `ADDR_TUNE,
                `ADDR_IRQEN, `ADDR_IRQFLAG, `ADDR_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    assign setup = psel & ~penable;
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign rd = access & ~pwrite;

    assign crystal = cfg_q[`CFG_MODE_MSB:0] <= `MODE_CRYSTAL_MAX;
    assign int_primary = cfg_q[`MODE_INT_BIT];
    assign two_speed = crystal &
        (cfg_q[`CFG_DUAL_BIT] | cfg_q[`CFG_FMON_BIT]);
    assign start_ok = ~crystal | start_done_q;
    assign start_fin = start_run_q & osc_rise[0] &
        (start_cnt_q == START_LAST);

    assign sel_src = oscctl_q[`OSC_SCS1_BIT] ? `SRC_INT :
        (oscctl_q[`OSC_SCS0_BIT] ? `SRC_SEC : `SRC_PRI);
    // two-speed start runs from internal while the count runs
    assign want = fail_q ? `SRC_INT :
        ((sel_src == `SRC_PRI) & two_speed & ~start_ok) ? `SRC_INT :
        sel_src;
    assign pri_ready = crystal ? start_done_q :
        (int_primary ? filt_q[4] : 1'b1);
    assign src_ready = {filt_q[4], filt_q[3], pri_ready};

    assign armed = cfg_q[`CFG_FMON_BIT] & start_ok & ~fail_q &
        (cur_q == `SRC_PRI) & ~state_q[4];
    assign fail_evt = armed & filt_q[5];

    assign scs1_tog = wr & (paddr == `ADDR_OSCCTL) &
        (pwdata[`OSC_SCS1_BIT] != oscctl_q[`OSC_SCS1_BIT]);
    assign sleep_enter = state_q[0] & sleep_request &
        ~oscctl_q[`OSC_IDLE_BIT];
    assign wake_restart = state_q[4] & wake_event;
    assign fail_clear = (scs1_tog & ~crystal) | (fail_q & start_fin);

    // synchronisers and strap capture
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 6'h00;
            s2_q <= 6'h00;
            s3_q <= 6'h00;
            filt_q <= 6'h00;
            cfg_q <= `CFG_RST;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            cfg_q <= {dual_speed_start_enable, fail_monitor_enable,
                      2'b00, osc_mode_strap};
        end
    end

    // start-up counter: counts primary oscillations
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_cnt_q <= 11'h000;
            start_run_q <= 1'b1;
            start_done_q <= 1'b0;
        end
        else if (wake_restart | scs1_tog)
        begin
            start_cnt_q <= 11'h000;
            start_run_q <= 1'b1;
            start_done_q <= 1'b0;
        end
        else if (sleep_enter)
        begin
            start_run_q <= 1'b0;
            start_done_q <= 1'b0;
        end
        else if (start_run_q & osc_rise[0])
        begin
            if (start_cnt_q == START_LAST)
            begin
                start_run_q <= 1'b0;
                start_done_q <= 1'b1;
            end
            else
            begin
                start_cnt_q <= start_cnt_q + 11'h001;
            end
        end
    end

    // fail condition: held until reset, a select toggle on a non-crystal primary, or the end of a start-up count
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fail_q <= 1'b0;
        else if (fail_evt)
            fail_q <= 1'b1;
        else if (fail_clear)
            fail_q <= 1'b0;
    end

    // clock switch and power mode sequencer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_WAIT;
            cur_q <= `SRC_NONE;
            tgt_q <= `SRC_NONE;
            edge_cnt_q <= 4'h0;
            primary_ready_flag_q <= 1'b0;
            internal_stable_flag_q <= 1'b0;
            secondary_flag_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_RUN:
                begin
                    if (sleep_request)
                    begin
                        if (oscctl_q[`OSC_IDLE_BIT])
                            state_q <= ST_IDLE;
                        else
                        begin
                            state_q <= ST_SLEEP;
                            cur_q <= `SRC_NONE;
                            primary_ready_flag_q <= 1'b0;
                            internal_stable_flag_q <= 1'b0;
                            secondary_flag_q <= 1'b0;
                        end
                    end
                    else if (want != cur_q)
                    begin
                        tgt_q <= want;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    edge_cnt_q <= 4'h0;
                    if (want != tgt_q)
                        tgt_q <= want;
                    else if (want == cur_q)
                        state_q <= ST_RUN;
                    else if (pick(tgt_q, src_ready))
                    begin
                        // a dead or absent old clock gives no edges
                        if (cur_q == `SRC_NONE ||
                            (fail_q && cur_q == `SRC_PRI))
                            state_q <= ST_NEW;
                        else
                            state_q <= ST_OLD;
                    end
                end
                ST_OLD:
                begin
                    if (pick(cur_q, osc_rise))
                    begin
                        if (edge_cnt_q == OLD_LAST)
                        begin
                            edge_cnt_q <= 4'h0;
                            state_q <= ST_NEW;
                        end
                        else
                            edge_cnt_q <= edge_cnt_q + 4'h1;
                    end
                end
                ST_NEW:
                begin
                    if (pick(tgt_q, osc_rise))
                    begin
                        if (edge_cnt_q == NEW_LAST)
                        begin
                            edge_cnt_q <= 4'h0;
                            state_q <= ST_RUN;
                            cur_q <= tgt_q;
                            primary_ready_flag_q <=
                                (tgt_q == `SRC_PRI);
                            internal_stable_flag_q <=
                                ((tgt_q == `SRC_INT) &&
                                 (oscctl_q[`OSC_FREQ_MSB:`OSC_FREQ_LSB]
                                  != `FREQ_SLOW)) ||
                                ((tgt_q == `SRC_PRI) && int_primary);
                            secondary_flag_q <=
                                (tgt_q == `SRC_SEC);
                        end
                        else
                            edge_cnt_q <= edge_cnt_q + 4'h1;
                    end
                end
                ST_SLEEP:
                begin
                    if (wake_event)
                    begin
                        state_q <= ST_WAIT;
                        tgt_q <= `SRC_NONE;
                    end
                end
                ST_IDLE:
                begin
                    if (wake_event)
                        state_q <= ST_RUN;
                end
                default:
                begin
                    state_q <= ST_WAIT;
                    cur_q <= `SRC_NONE;
                end
            endcase
        end
    end

    // software registers over APB
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            intctl_q <= `INTCTL_RST;
            oscctl_q <= `OSCCTL_RST;
            tune_q <= `TUNE_RST;
            irqen_q <= `IRQEN_RST;
            irqflag_q <= `IRQFLAG_RST;
        end
        else
        begin
            if (wr)
            begin
                case (paddr)
                    `ADDR_INTCTL: intctl_q <= pwdata[7:0];
                    `ADDR_OSCCTL: oscctl_q <= pwdata[7:0];
                    `ADDR_TUNE: tune_q <= pwdata[7:0];
                    `ADDR_IRQEN: irqen_q <= pwdata[7:0];
                    `ADDR_IRQFLAG:
                        irqflag_q[`FAIL_BIT-1:0] <=
                            pwdata[`FAIL_BIT-1:0];
                    default: intctl_q <= intctl_q;
                endcase
            end
            // a read clears the fail flag, a new failure wins
            if (fail_evt)
                irqflag_q[`FAIL_BIT] <= 1'b1;
            else if (rd && paddr == `ADDR_IRQFLAG)
                irqflag_q[`FAIL_BIT] <= 1'b0;
        end
    end

    // bus answer: ready in the access cycle, data loaded at setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~mapped(paddr);
            if (setup)
            begin
                case (paddr)
                    `ADDR_CFG: prdata <= {24'h000000, cfg_q};
                    `ADDR_INTCTL: prdata <= {24'h000000, intctl_q};
                    `ADDR_OSCCTL:
                        prdata <= {24'h000000,
                                   oscctl_q[7:4],
                                   primary_ready_flag_q,
                                   internal_stable_flag_q,
                                   oscctl_q[1:0]};
                    `ADDR_TUNE: prdata <= {24'h000000, tune_q};
                    `ADDR_IRQEN: prdata <= {24'h000000, irqen_q};
                    `ADDR_IRQFLAG: prdata <= {24'h000000, irqflag_q};
                    `ADDR_STATUS:
                        prdata <= {16'h0000, 2'b00, state_q,
                                   cur_q, start_done_q, fail_q,
                                   3'b000, secondary_flag_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // registered clock gates and status outputs
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clk_enable <= 1'b0;
            periph_clk_enable <= 1'b0;
            system_clk_source <= `SRC_NONE;
            secondary_running_flag <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            // system clock held low during the new-clock edges
            cpu_clk_enable <= (cur_q != `SRC_NONE) &
                (state_q[0] | state_q[1] | state_q[2]);
            periph_clk_enable <= (cur_q != `SRC_NONE) &
                (state_q[0] | state_q[1] | state_q[2] |
                 state_q[5]);
            system_clk_source <= cur_q;
            secondary_running_flag <= secondary_flag_q;
            irq <= |(irqflag_q & irqen_q);
        end
    end

endmodule
`default_nettype wire

// file: tb/osc_model.sv
// oscillator pins and ready levels seen by the clock select block
`timescale 1ns/1ns
`default_nettype none
module osc_model (
    input wire logic sec_on,
    input wire logic fail_on,
    output logic primary_osc_in,
    output logic secondary_osc_in,
    output logic internal_osc_in,
    output logic secondary_osc_ready,
    output logic fast_internal_osc_stable,
    output logic primary_fail_detect
);
    initial
    begin
        primary_osc_in = 1'b0;
        secondary_osc_in = 1'b0;
        internal_osc_in = 1'b0;
        fast_internal_osc_stable = 1'b0;
        #40 fast_internal_osc_stable = 1'b1;
    end
    // toggles fall between clock edges and every level spans two or
    // more samples, so the three-stage filter sees each edge
    // a failed crystal stops toggling
    always #8 if (!fail_on) primary_osc_in = ~primary_osc_in;
    always #16 if (sec_on) secondary_osc_in = ~secondary_osc_in;
    always #12 internal_osc_in = ~internal_osc_in;
    assign secondary_osc_ready = sec_on;
    assign primary_fail_detect = fail_on;
endmodule
`default_nettype wire

// file: tb/power_mode_checker_properties.sv
// port checks for the power mode clock select block
`timescale 1ns/1ns
`default_nettype none
module power_mode_checker #(
    parameter STARTUP_COUNT = 1024,
    parameter OLD_EDGES = 3,
    parameter NEW_EDGES = 3
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sleep_request,
    input wire cpu_clk_enable,
    input wire periph_clk_enable,
    input wire [1:0] system_clk_source,
    input wire secondary_running_flag,
    input wire irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_cpu_needs_periph: assert property (
        cpu_clk_enable |-> periph_clk_enable)
        else $error("cpu clocked without peripherals");
    a_none_all_off: assert property (
        system_clk_source == 2'b11 |-> !periph_clk_enable)
        else $error("clock enabled with no source");
    a_switch_gated: assert property (
        $changed(system_clk_source) && system_clk_source != 2'b11
        |-> !$past(periph_clk_enable) && !$past(periph_clk_enable, 2))
        else $error("source changed without gating");
    a_sec_flag_src: assert property (
        $rose(secondary_running_flag) |-> ##[0:2] system_clk_source == 2'b01)
        else $error("secondary flag without secondary source");
    a_sec_flag_drop: assert property (
        $fell(secondary_running_flag)
        |-> ##[0:2] system_clk_source != 2'b01)
        else $error("secondary flag dropped while still secondary");
    a_sleep_cpu_off: assert property (
        sleep_request && cpu_clk_enable |-> ##[1:3] !cpu_clk_enable)
        else $error("cpu still clocked after sleep request");
    a_irq_falls_access: assert property (
        $fell(irq) |-> $past(penable, 2) && $past(pready, 2))
        else $error("interrupt dropped without register access");
    a_ready_after_setup: assert property (
        psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (
        pslverr |-> pready && prdata[31:8] == 24'h0)
        else $error("error without ready");

    c_idle: cover property (sleep_request ##2 (!cpu_clk_enable && periph_clk_enable));
    c_secondary: cover property ($rose(secondary_running_flag));
    c_irq_clear: cover property ($fell(irq));
endmodule

bind power_mode_clock_select power_mode_checker #(
    .STARTUP_COUNT(STARTUP_COUNT), .OLD_EDGES(OLD_EDGES),
    .NEW_EDGES(NEW_EDGES)
) chk (.*);
`default_nettype wire

// file: tb/test_power_mode_clock_select.sv
// self-checking bench for the power mode clock select block
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_defs.vh"
module test_power_mode_clock_select;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] osc_mode_strap = 4'h0;
    logic fail_monitor_enable = 1'b1;
    logic dual_speed_start_enable = 1'b0;
    logic sleep_request = 1'b0;
    logic wake_event = 1'b0;
    logic sec_on = 1'b0;
    logic fail_on = 1'b0;
    logic err;
    int num_errors = 0;
    int check_count = 0;
    wire [31:0] prdata;
    wire pready, pslverr, cpu_clk_enable, periph_clk_enable, irq;
    wire primary_osc_in, secondary_osc_in, internal_osc_in;
    wire secondary_osc_ready, fast_internal_osc_stable, primary_fail_detect;
    wire secondary_running_flag;
    wire [1:0] system_clk_source;
    wire [3:0] obs;

    assign obs = {cpu_clk_enable, periph_clk_enable, system_clk_source};
    power_mode_clock_select #(.STARTUP_COUNT(8)) dut (.*);
    osc_model osc (.*);
    always #2 pclk = ~pclk;

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, {24'h0, e});
    endtask

    // bounded wait until the masked clock outputs reach a value
    task automatic wait_obs(input logic [3:0] m, input logic [3:0] v);
        int n;
        n = 0;
        while ((obs & m) !== v && n < 600)
        begin
            @(posedge pclk);
            n++;
        end
        check({28'h0, obs & m}, {28'h0, v});
    endtask

    task automatic pulse(input logic wake);
        if (wake)
            wake_event <= 1'b1;
        else
            sleep_request <= 1'b1;
        @(posedge pclk);
        wake_event <= 1'b0;
        sleep_request <= 1'b0;
    endtask

    task automatic t_start;
        wait_obs(4'hf, {2'b11, `SRC_INT});
        rd(`ADDR_OSCCTL, 8'h34);
        fail_on <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(`ADDR_IRQFLAG, 8'h00);
        fail_on <= 1'b0;
        wait_obs(4'h3, {2'b00, `SRC_PRI});
        rd(`ADDR_OSCCTL, 8'h38);
    endtask

    task automatic t_regs;
        logic [31:0] q;
        wr(`ADDR_TUNE, 8'ha5);
        rd(`ADDR_TUNE, 8'ha5);
        wr(`ADDR_CFG, 8'hff);
        rd(`ADDR_CFG, 8'h40);
        apb(1'b0, 12'h01c, 32'h0, q);
        check({31'h0, err}, 32'h1);
        check(q, 32'h0);
    endtask

    task automatic t_switch;
        logic [7:0] sel [5] = '{8'h31, 8'h30, 8'h32, 8'h33, 8'h30};
        logic [7:0] osv [5] = '{8'h31, 8'h38, 8'h36, 8'h37, 8'h38};
        logic [1:0] src [5] = '{`SRC_SEC, `SRC_PRI, `SRC_INT, `SRC_INT, `SRC_PRI};
        logic [1:0] prev;
        prev = `SRC_PRI;
        wr(`ADDR_OSCCTL, sel[0]);
        repeat (40) @(posedge pclk);
        check({30'h0, system_clk_source}, {30'h0, prev});
        sec_on <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            if (i > 0)
                wr(`ADDR_OSCCTL, sel[i]);
            check({30'h0, system_clk_source}, {30'h0, prev});
            wait_obs(4'h3, {2'b00, src[i]});
            rd(`ADDR_OSCCTL, osv[i]);
            check({31'h0, secondary_running_flag}, {31'h0, src[i] == 2'b01});
            prev = src[i];
        end
    endtask

    task automatic t_sleep;
        wr(`ADDR_OSCCTL, 8'hb0);
        pulse(1'b0);
        wait_obs(4'hf, 4'h4);
        wr(`ADDR_OSCCTL, 8'h30);
        repeat (5) @(posedge pclk);
        check({28'h0, obs}, 32'h4);
        pulse(1'b1);
        wait_obs(4'hf, 4'hc);
        pulse(1'b0);
        wait_obs(4'hc, 4'h0);
        rd(`ADDR_OSCCTL, 8'h30);
        pulse(1'b1);
        wait_obs(4'h3, {2'b00, `SRC_INT});
        wait_obs(4'hf, {2'b11, `SRC_PRI});
    endtask

    task automatic t_fail;
        wr(`ADDR_IRQEN, 8'h00);
        fail_on <= 1'b1;
        wait_obs(4'h3, {2'b00, `SRC_INT});
        fail_on <= 1'b0;
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQEN, 8'h80);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rd(`ADDR_IRQFLAG, 8'h80);
        rd(`ADDR_IRQFLAG, 8'h00);
        check({31'h0, irq}, 32'h0);
        rd(`ADDR_OSCCTL, 8'h34);
        wr(`ADDR_OSCCTL, 8'h32);
        wr(`ADDR_OSCCTL, 8'h30);
        wait_obs(4'h3, {2'b00, `SRC_PRI});
    endtask

    // external clock strap: no start-up count, monitor live at once
    task automatic t_ext;
        osc_mode_strap <= 4'h4;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_obs(4'h4, 4'h4);
        check({30'h0, system_clk_source}, {30'h0, `SRC_PRI});
        rd(`ADDR_OSCCTL, 8'h38);
        fail_on <= 1'b1;
        wait_obs(4'h3, {2'b00, `SRC_INT});
        fail_on <= 1'b0;
        // internal oscillator strapped as primary shows both flags
        osc_mode_strap <= 4'h8;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_obs(4'hf, {2'b11, `SRC_PRI});
        rd(`ADDR_OSCCTL, 8'h3c);
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_start;
        t_regs;
        t_switch;
        t_sleep;
        t_fail;
        t_ext;
        tally_and_finish;
    end

    initial
    begin
        #200000;
        num_errors++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
